// File: hdl/tui_avs_slave.sv
// Avalon-MM slave front end with one wait state per access
`timescale 1ns/1ps
module tui_avs_slave
  import tui_pkg::*;
(
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         resetn,
  // Avalon-MM slave
  input  wire logic [7:0]   avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  input  wire logic [3:0]   avs_byteenable,
  output logic      [31:0]  avs_readdata,
  output logic              avs_waitrequest,
  // Register file side
  input  wire logic [7:0]   rd_word,
  output tui_reg_acc_t      acc
);

  typedef enum logic [1:0] {
    TUI_S_IDLE = 2'b01,
    TUI_S_ACK  = 2'b10
  } tui_bus_state_t;

  typedef struct packed {
    tui_bus_state_t st;
    logic [31:0]    rdata;
  } tui_avs_state_t;

  tui_avs_state_t q, d;

  // Sequencing: capture read data, then release the request
  always_comb begin
    d = q;
    case (q.st)
      TUI_S_IDLE: begin
        if (avs_read || avs_write) begin
          d.st = TUI_S_ACK;
        end
        if (avs_read) begin
          d.rdata = {24'h0, rd_word};
        end
      end
      TUI_S_ACK: d.st = TUI_S_IDLE;
      default:   d.st = TUI_S_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      q <= '{st: TUI_S_IDLE, rdata: 32'h0};
    end else begin
      q <= d;
    end
  end

  // Handshake and access strobes
  assign avs_waitrequest = (avs_read || avs_write) && (q.st == TUI_S_IDLE);
  assign avs_readdata    = q.rdata;
  assign acc.wr    = avs_write && (q.st == TUI_S_ACK) && avs_byteenable[0];
  assign acc.rd    = avs_read && (q.st == TUI_S_ACK);
  assign acc.idx   = tui_word_index(avs_address);
  assign acc.wdata = avs_writedata[7:0];

endmodule

// File: hdl/tui_pkg.sv
// Shared constants, types and helpers of the time update interrupt block
package tui_pkg;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int PULSE_TIME_NS = 7_570_000;  // 7.57 ms least low time
  localparam int PULSE_CYCLES  = (PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------------
  localparam logic [7:0] IDX_EXT_CTRL   = 8'h1d;
  localparam logic [7:0] IDX_EVT_FLAGS  = 8'h1e;
  localparam logic [7:0] IDX_IRQ_CTRL   = 8'h1f;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
  localparam logic [7:0] IDX_IRQ_MASK   = 8'h21;
  localparam logic [7:0] IDX_NONE       = 8'hff;

  // ---------------------------------------------------------------------
  // Field positions, masks and reset values
  // ---------------------------------------------------------------------
  localparam int         EXT_PERIOD_SEL_BIT = 5;
  localparam int         FLG_UPD_BIT        = 5;
  localparam int         CTL_UPD_IE_BIT     = 5;
  localparam int         CTL_HALT_BIT       = 0;
  localparam logic [7:0] CTL_RW_MASK        = 8'h3d;
  localparam logic [7:0] EXT_CTRL_RST       = 8'h00;
  localparam logic [7:0] IRQ_CTRL_RST       = 8'h00;
  localparam int         IST_W              = 2;
  localparam int         IST_UPD_BIT        = 0;
  localparam int         IST_REL_BIT        = 1;
  localparam logic [1:0] IST_RST            = 2'h0;
  localparam logic [1:0] IMSK_RST           = 2'h0;

  // ---------------------------------------------------------------------
  // Register access handed from the bus slave to the register file
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] idx;
    logic [7:0] wdata;
  } tui_reg_acc_t;

  // Word index of an aligned byte address, none for an unaligned one
  function automatic logic [7:0] tui_word_index(input logic [7:0] addr);
    return (addr[1:0] == 2'h0) ? {2'h0, addr[7:2]} : IDX_NONE;
  endfunction

  // Access hits a given register index
  function automatic logic tui_idx_hit(input tui_reg_acc_t a, input logic [7:0] idx);
    return a.idx == idx;
  endfunction

endpackage

// File: hdl/tui_pulse_timer.sv
// Retriggerable pulse timer for the interrupt pin low time
`timescale 1ns/1ps
module tui_pulse_timer
  import tui_pkg::*;
#(
  parameter int CYCLES = PULSE_CYCLES
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic resetn,
  // Control
  input  wire logic start,
  input  wire logic cancel,
  // Status
  output logic      active,
  output logic      expired
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          active;
    logic          expired;
  } tui_tmr_state_t;

  tui_tmr_state_t q, d;

  // Start wins over cancel so a fresh event is never dropped
  always_comb begin
    d = q;
    d.expired = 1'b0;
    if (start) begin
      d.active = 1'b1;
      d.cnt    = LOAD;
    end else if (cancel) begin
      d.active = 1'b0;
      d.cnt    = '0;
    end else if (q.active) begin
      if (q.cnt == '0) begin
        d.active  = 1'b0;
        d.expired = 1'b1;
      end else begin
        d.cnt = q.cnt - 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign active  = q.active;
  assign expired = q.expired;

endmodule

// File: hdl/tui_top.sv
// Time update interrupt block: registers, event logic, pin and interrupt
//
// How it works
// - An update event follows each seconds or minutes tick, per the period select.
// - After an event pulls the pin low, it releases itself no sooner than 7.57 ms.
// - While the counter halt bit is 1, no update events are raised.
// - Events and the flag run regardless of enable; enable only gates the pin.
// - With enable at 0 the update event never drives the pin low.
// - Enable at 0 masks only the update share; other sources still drive the pin.
// - Period select is read/write: 0 gives per second, 1 per minute events.
// - Every update event sets the update flag to 1.
// - The flag stays 1 until software clears it; pin release leaves it set.
// - Writing 0 clears the flag and cancels the pin low; writing 1 does nothing.
// - With enable at 1 each update event pulls the pin from released to low.
`timescale 1ns/1ps
module tui_top
  import tui_pkg::*;
#(
  parameter int PULSE_LEN = PULSE_CYCLES
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Counter chain
  input  wire logic        sec_tick,
  input  wire logic        min_tick,
  output logic             counter_halt,
  // Other interrupt sources of the device
  input  wire logic        other_irq_req,
  // Open-drain interrupt pin
  output logic             int_pin_o,
  output logic             int_pin_oe_n,
  // System interrupt
  output logic             irq
);

  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]       ext;
    logic [7:0]       ctl;
    logic             uf;
    logic [IST_W-1:0] ist;
    logic [IST_W-1:0] imsk;
    logic             pin_oe_n;
    logic             irq;
  } tui_top_state_t;

  tui_top_state_t q, d;
  tui_reg_acc_t   acc;
  logic [7:0]     rd_word;
  logic           period_sel;
  logic           upd_ie;
  logic           halt;
  logic           upd_event;
  logic           uf_clr;
  logic           upd_active;
  logic           upd_expired;
  logic           pin_drive;
  logic [IST_W-1:0] ist_set;
  logic [IST_W-1:0] ist_clr;

  // -----------------------------------------------------------------------
  // Bus slave and pulse timer
  // -----------------------------------------------------------------------
  tui_avs_slave u_avs (
    .core_clk        (core_clk),
    .resetn          (resetn),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .rd_word         (rd_word),
    .acc             (acc)
  );

  tui_pulse_timer #(
    .CYCLES (PULSE_LEN)
  ) u_tmr (
    .core_clk (core_clk),
    .resetn   (resetn),
    .start    (upd_event),
    .cancel   (uf_clr),
    .active   (upd_active),
    .expired  (upd_expired)
  );

  // -----------------------------------------------------------------------
  // Event generation
  // -----------------------------------------------------------------------
  // Control fields
  assign period_sel   = q.ext[EXT_PERIOD_SEL_BIT];
  assign upd_ie       = q.ctl[CTL_UPD_IE_BIT];
  assign halt         = q.ctl[CTL_HALT_BIT];
  assign counter_halt = halt;

  // Tick chosen by period select, blocked while halted
  assign upd_event = !halt && (period_sel ? min_tick : sec_tick);

  // Write of 0 to the flag bit clears it
  assign uf_clr = acc.wr && tui_idx_hit(acc, IDX_EVT_FLAGS) && !acc.wdata[FLG_UPD_BIT];

  // Update share gated by enable, other sources always pass
  assign pin_drive = (upd_active && upd_ie) || other_irq_req;

  // Interrupt status events and read clear of the bits returned
  assign ist_set = {upd_expired, upd_event};
  assign ist_clr = (acc.rd && tui_idx_hit(acc, IDX_IRQ_STATUS)) ?
                   avs_readdata[IST_W-1:0] : 2'h0;

  // -----------------------------------------------------------------------
  // Read mux
  // -----------------------------------------------------------------------
  always_comb begin
    rd_word = 8'h00;
    if (acc.idx == IDX_EXT_CTRL) begin
      rd_word = q.ext;
    end else if (acc.idx == IDX_EVT_FLAGS) begin
      rd_word = 8'h00;
      rd_word[FLG_UPD_BIT] = q.uf;
    end else if (acc.idx == IDX_IRQ_CTRL) begin
      rd_word = q.ctl;
    end else if (acc.idx == IDX_IRQ_STATUS) begin
      rd_word = {6'h00, q.ist};
    end else if (acc.idx == IDX_IRQ_MASK) begin
      rd_word = {6'h00, q.imsk};
    end
  end

  // -----------------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------------
  always_comb begin
    d = q;
    // Register writes
    if (acc.wr) begin
      if (tui_idx_hit(acc, IDX_EXT_CTRL)) begin
        d.ext = acc.wdata;
      end else if (tui_idx_hit(acc, IDX_IRQ_CTRL)) begin
        d.ctl = acc.wdata & CTL_RW_MASK;
      end else if (tui_idx_hit(acc, IDX_IRQ_MASK)) begin
        d.imsk = acc.wdata[IST_W-1:0];
      end
    end
    // Flag: set wins over clear, release never clears
    if (uf_clr) begin
      d.uf = 1'b0;
    end
    if (upd_event) begin
      d.uf = 1'b1;
    end
    // Sticky status, set wins over read clear
    d.ist = (q.ist & ~ist_clr) | ist_set;
    d.irq = |(q.ist & q.imsk);
    // Pin enable registered, low while driving
    d.pin_oe_n = !pin_drive;
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      q <= '{ext: EXT_CTRL_RST, ctl: IRQ_CTRL_RST, uf: 1'b0, ist: IST_RST,
             imsk: IMSK_RST, pin_oe_n: 1'b1, irq: 1'b0};
    end else begin
      q <= d;
    end
  end

  // Outputs
  assign int_pin_o    = 1'b0;
  assign int_pin_oe_n = q.pin_oe_n;
  assign irq          = q.irq;

  // -----------------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // Length of the current update low pulse
  int unsigned run_cnt;
  always_ff @(posedge core_clk) begin
    if (!resetn || !upd_active) begin
      run_cnt <= 0;
    end else begin
      run_cnt <= run_cnt + 1;
    end
  end

  // Event then enable still set one cycle later
  sequence s_update_kick;
    upd_event ##1 (upd_ie && !uf_clr && !upd_event);
  endsequence

  // Flag clear taken with no competing event
  sequence s_flag_clear;
    uf_clr && !upd_event;
  endsequence

  chk_second_tick_event : assert property (
    (sec_tick && !period_sel && !halt) |=> (upd_active && q.uf))
    else $error("seconds tick gave no update event");

  chk_minute_tick_event : assert property (
    (min_tick && period_sel && !halt) |=> (upd_active && q.uf))
    else $error("minutes tick gave no update event");

  chk_pulse_min_len : assert property (
    $fell(upd_active) |-> ($past(uf_clr) || run_cnt >= PULSE_LEN))
    else $error("update pulse ended early");

  chk_halt_no_event : assert property (
    (halt && !q.uf && !uf_clr) |=> !q.uf)
    else $error("update flag set while halted");

  chk_flag_without_ie : assert property (
    (upd_event && !upd_ie) |=> (q.uf && upd_active))
    else $error("event lost with enable off");

  chk_pin_quiet_off : assert property (
    (!upd_ie && !other_irq_req) |=> int_pin_oe_n)
    else $error("pin driven by update with enable off");

  chk_other_source : assert property (
    other_irq_req |=> !int_pin_oe_n)
    else $error("other source not driving pin");

  chk_period_write : assert property (
    (acc.wr && tui_idx_hit(acc, IDX_EXT_CTRL)) |=>
      (period_sel == $past(acc.wdata[EXT_PERIOD_SEL_BIT])))
    else $error("period select not written");

  chk_flag_set : assert property (
    upd_event |=> q.uf)
    else $error("update flag not set");

  chk_flag_holds : assert property (
    (q.uf && !uf_clr) |=> q.uf)
    else $error("update flag cleared itself");

  chk_flag_clear : assert property (
    s_flag_clear |=> (!q.uf && !upd_active) ##1 (int_pin_oe_n || $past(other_irq_req)))
    else $error("flag clear did not cancel pin");

  chk_pin_low_kick : assert property (
    s_update_kick |=> !int_pin_oe_n)
    else $error("enabled event did not pull pin low");

  chk_pin_open_drain : assert property (
    (int_pin_o == 1'b0) && (int_pin_oe_n == !$past(pin_drive)))
    else $error("pin level or enable wrong");

  chk_irq_level : assert property (
    (|(q.ist & q.imsk)) |=> irq)
    else $error("masked status not raising irq");

  chk_irq_falls : assert property (
    !(|(q.ist & q.imsk)) |=> !irq)
    else $error("irq stayed high with no unmasked status");

  chk_status_event : assert property (
    upd_event |=> q.ist[IST_UPD_BIT])
    else $error("update status bit not set");

  chk_status_expiry : assert property (
    upd_expired |=> q.ist[IST_REL_BIT])
    else $error("release status bit not set");

  // Status read with no competing status event
  sequence s_status_read;
    acc.rd && tui_idx_hit(acc, IDX_IRQ_STATUS) && !upd_event && !upd_expired;
  endsequence

  chk_status_rdclr : assert property (
    s_status_read |=> ((q.ist & $past(avs_readdata[IST_W-1:0])) == 2'h0))
    else $error("status bits survived their read");

  chk_one_wait : assert property (
    ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
    else $error("more than one wait state");

  chk_wait_again : assert property (
    ((avs_read || avs_write) && !avs_waitrequest) |=>
      (avs_waitrequest || !(avs_read || avs_write)))
    else $error("back to back request skipped its wait state");

  chk_read_upper : assert property (
    (avs_read && !avs_waitrequest) |-> (avs_readdata[31:8] == 24'h0))
    else $error("read data upper bits not zero");

  chk_halt_no_pulse : assert property (
    (halt && !upd_active) |=> !upd_active)
    else $error("pulse started while halted");

  chk_expiry_release : assert property (
    (upd_expired && !other_irq_req) |=> int_pin_oe_n)
    else $error("pin not released after pulse time");

  chk_pin_follows : assert property (
    (upd_active && upd_ie) |=> !int_pin_oe_n)
    else $error("enabled pulse not driving pin");

  chk_wrong_period : assert property (
    ((period_sel ? (sec_tick && !min_tick) : (min_tick && !sec_tick)) && !uf_clr) |=>
      (q.uf == $past(q.uf)))
    else $error("tick of unselected period changed flag");

  chk_ctl_write : assert property (
    (acc.wr && tui_idx_hit(acc, IDX_IRQ_CTRL)) |=>
      (q.ctl == ($past(acc.wdata) & CTL_RW_MASK)))
    else $error("control byte not stored");

  chk_mask_write : assert property (
    (acc.wr && tui_idx_hit(acc, IDX_IRQ_MASK)) |=>
      (q.imsk == $past(acc.wdata[IST_W-1:0])))
    else $error("mask not stored");

  chk_flag_write_one : assert property (
    (acc.wr && tui_idx_hit(acc, IDX_EVT_FLAGS) && acc.wdata[FLG_UPD_BIT]) |=>
      (q.uf == ($past(q.uf) || $past(upd_event))))
    else $error("writing 1 changed the update flag");

  // Write that must leave the stored bytes alone
  sequence s_write_ignored;
    (acc.wr && !tui_idx_hit(acc, IDX_EXT_CTRL) && !tui_idx_hit(acc, IDX_IRQ_CTRL) &&
     !tui_idx_hit(acc, IDX_IRQ_MASK)) ||
    (avs_write && !avs_waitrequest && !avs_byteenable[0]);
  endsequence

  chk_write_ignored : assert property (
    s_write_ignored |=>
      (q.ext == $past(q.ext) && q.ctl == $past(q.ctl) && q.imsk == $past(q.imsk)))
    else $error("ignored write changed a register");

endmodule

// File: verification/tui_bench.sv
// Self-checking bench of the time update interrupt block
`timescale 1ns/1ps
module tui_bench;
  import tui_pkg::*;
  localparam int         PLEN   = 20;
  localparam logic [7:0] A_EXT  = {IDX_EXT_CTRL[5:0], 2'h0};
  localparam logic [7:0] A_FLG  = {IDX_EVT_FLAGS[5:0], 2'h0};
  localparam logic [7:0] A_CTL  = {IDX_IRQ_CTRL[5:0], 2'h0};
  localparam logic [7:0] A_IST  = {IDX_IRQ_STATUS[5:0], 2'h0};
  localparam logic [7:0] A_IMSK = {IDX_IRQ_MASK[5:0], 2'h0};

  // ---------------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------------
  logic        core_clk = 1'b0, resetn = 1'b0;
  logic [7:0]  avs_address = 8'h0;
  logic        avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic        sec_tick = 1'b0, min_tick = 1'b0, other_irq_req = 1'b0;
  logic [31:0] avs_readdata, pulse_len;
  logic        avs_waitrequest, counter_halt, int_pin_o, int_pin_oe_n;
  logic        irq, int_line, pulse_done;
  int          num_errors = 0, samples_checked = 0, n;
  logic [7:0]  v;
  logic [7:0]  exp_rd[$];
  int          exp_len[$];

  // Clock of 100 MHz
  always #5 core_clk = ~core_clk;

  tui_top #(.PULSE_LEN(PLEN)) dut (
    .core_clk(core_clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sec_tick(sec_tick), .min_tick(min_tick),
    .counter_halt(counter_halt), .other_irq_req(other_irq_req),
    .int_pin_o(int_pin_o), .int_pin_oe_n(int_pin_oe_n), .irq(irq));

  tui_host_model host (
    .core_clk(core_clk), .resetn(resetn), .int_pin_o(int_pin_o),
    .int_pin_oe_n(int_pin_oe_n), .int_line(int_line), .pulse_done(pulse_done),
    .pulse_len(pulse_len));

  // ---------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One bus transfer, held until waitrequest is seen low
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d,
                     input logic [3:0] be);
    int k;
    @(posedge core_clk);
    avs_address    <= a;
    avs_read       <= ~w;
    avs_write      <= w;
    avs_writedata  <= {24'h0, d};
    avs_byteenable <= be;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 64);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (k >= 64) begin
      num_errors++;
      $display("[ERR] %0t bus wait ran out", $time);
      report_and_stop();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(a, 1'b1, d, 4'hf);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_rd.push_back(e);
    bus(a, 1'b0, 8'h0, 4'hf);
  endtask

  // One-cycle counter chain pulses
  task automatic tick(input logic s, input logic m);
    @(posedge core_clk);
    sec_tick <= s;
    min_tick <= m;
    @(posedge core_clk);
    sec_tick <= 1'b0;
    min_tick <= 1'b0;
  endtask

  // Let a full pulse time pass, then all noted pulses must have shown
  task automatic drain();
    repeat (PLEN + 8) @(posedge core_clk);
    if (exp_len.size() != 0) begin
      num_errors++;
      $display("[ERR] %0t expected pulse missing", $time);
      report_and_stop();
    end
  endtask

  // ---------------------------------------------------------------------
  // Result watcher: oldest note against each read and each pulse
  // ---------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      if (exp_rd.size() == 0) check(32'h1, 32'h0, "read without note");
      else check(avs_readdata, {24'h0, exp_rd.pop_front()}, "read data");
    end
    if (pulse_done === 1'b1) begin
      if (exp_len.size() == 0) check(pulse_len, 32'h0, "unexpected pulse");
      else if (exp_len[0] == 0) check({31'h0, pulse_len < PLEN}, 32'h1, "cut pulse");
      else check(pulse_len, exp_len[0], "pulse length");
      if (exp_len.size() != 0) void'(exp_len.pop_front());
    end
  end

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    void'($urandom(43));
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    // Reset values, unmapped and unaligned reads
    rd(A_EXT, EXT_CTRL_RST);
    rd(A_FLG, 8'h0);
    rd(A_CTL, IRQ_CTRL_RST);
    rd(A_IST, {6'h0, IST_RST});
    rd(A_IMSK, {6'h0, IMSK_RST});
    rd(8'h90, 8'h0);
    rd(8'h75, 8'h0);
    check(int_pin_oe_n, 32'h1, "idle pin");
    // Control bytes hold what was written, the IRQ control byte only its CTL_RW_MASK bits
    v = 8'($urandom);
    wr(A_EXT, v);
    rd(A_EXT, v);
    bus(A_EXT, 1'b1, ~v, 4'h0);
    rd(A_EXT, v);
    v = 8'($urandom);
    wr(A_CTL, v);
    rd(A_CTL, v & CTL_RW_MASK);
    wr(8'h90, v);
    rd(8'h90, 8'h0);
    wr(A_CTL, 8'h0);
    wr(A_EXT, 8'h0);
    wr(A_FLG, 8'h0);
    // Seconds period, enable on: minute ticks do nothing
    wr(A_CTL, 8'h20);
    exp_len.push_back(PLEN);
    tick(1'b1, 1'b0);
    drain();
    rd(A_FLG, 8'h20);
    tick(1'b0, 1'b1);
    drain();
    wr(A_FLG, 8'hff);
    rd(A_FLG, 8'h20);
    wr(A_FLG, 8'h0);
    rd(A_FLG, 8'h0);
    // Minute period: second ticks do nothing
    wr(A_CTL, 8'h0);
    wr(A_EXT, 8'h20);
    wr(A_CTL, 8'h20);
    tick(1'b1, 1'b0);
    drain();
    exp_len.push_back(PLEN);
    tick(1'b0, 1'b1);
    drain();
    // Flag clear in mid pulse cuts the pin short
    exp_len.push_back(0);
    tick(1'b0, 1'b1);
    repeat (2 + $urandom_range(0, 8)) @(posedge core_clk);
    wr(A_FLG, 8'h0);
    drain();
    // Enable off: flag still set, pin left alone
    wr(A_CTL, 8'h0);
    tick(1'b0, 1'b1);
    drain();
    rd(A_FLG, 8'h20);
    wr(A_FLG, 8'h0);
    // Another source still reaches the pin
    n = $urandom_range(3, 12);
    exp_len.push_back(n);
    @(posedge core_clk);
    other_irq_req <= 1'b1;
    repeat (n) @(posedge core_clk);
    other_irq_req <= 1'b0;
    drain();
    // Halt blocks all events
    wr(A_CTL, 8'h21);
    @(negedge core_clk);
    check(counter_halt, 32'h1, "halt out");
    tick(1'b1, 1'b1);
    drain();
    rd(A_FLG, 8'h0);
    wr(A_CTL, 8'h20);
    // Status, mask and interrupt line
    rd(A_IST, 8'h03);
    rd(A_IST, 8'h00);
    wr(A_IMSK, 8'h01);
    exp_len.push_back(PLEN);
    tick(1'b0, 1'b1);
    repeat (3) @(negedge core_clk);
    check(irq, 32'h1, "irq raised");
    drain();
    rd(A_IST, 8'h03);
    repeat (2) @(negedge core_clk);
    check(irq, 32'h0, "irq after read");
    wr(A_IMSK, 8'h00);
    exp_len.push_back(PLEN);
    tick(1'b0, 1'b1);
    repeat (3) @(negedge core_clk);
    check(irq, 32'h0, "irq masked");
    drain();
    rd(A_IST, 8'h03);
    rd(A_FLG, 8'h20);
    repeat (4) @(posedge core_clk);
    report_and_stop();
  end
endmodule

// File: verification/tui_host_model.sv
// Host side model: pulled-up interrupt line and low pulse meter
`timescale 1ns/1ps
module tui_host_model (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // Open-drain pin of the device
  input  wire logic        int_pin_o,
  input  wire logic        int_pin_oe_n,
  // Line level and measured pulses
  output logic             int_line,
  output logic             pulse_done,
  output logic [31:0]      pulse_len
);
  logic [31:0] low_cnt_q;

  // Pull-up holds the line high whenever the device lets go
  assign int_line = int_pin_oe_n ? 1'b1 : int_pin_o;

  // Count low cycles, report the length at each release
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      low_cnt_q  <= 32'h0;
      pulse_done <= 1'b0;
      pulse_len  <= 32'h0;
    end else begin
      pulse_done <= 1'b0;
      if (int_line === 1'b0) begin
        low_cnt_q <= low_cnt_q + 32'h1;
      end else if (low_cnt_q != 32'h0) begin
        pulse_done <= 1'b1;
        pulse_len  <= low_cnt_q;
        low_cnt_q  <= 32'h0;
      end
    end
  end
endmodule
